// ---- verilog/prcc_contact_ctrl.sv ----
`timescale 1ns/1ns
// How it works
// - Keyer on at fall, off at rise
// - Continuous jam on at fall, off rise
// - Brief low pulse gives one jam sync
// - Generator on at fall, off at rise
// - Time-to-UB fall: reader time mode, else static
// - UB-to-UB fall: reader UB mode, else static
// - Remote mode encodes inputs into user bits
// - Remote mode suppresses normal input functions
// - Other modes restore normal edge functions
// - Any edge reselects parallel as source
// - Serial 8A loads bits in remote mode only; levels ignored until edge
// - Byte 1 codes 81,82,84,88,90 per input
module prcc_contact_ctrl
	import prcc_pkg::*;
#(
	parameter int DEB_CNT = DEB_CYCLES,
	parameter int MOM_CNT = MOM_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [NUM_CH-1:0] contact_n,
	input wire logic remote_mode,
	input wire logic serial_cmd_valid,
	input wire logic [7:0] serial_cmd,
	input wire logic [7:0] serial_ub,
	output prcc_ctrl_t ctrl,
	output logic jam_once,
	output logic [7:0] generator_user_bits,
	output logic src_parallel
);

	// ****************************************
	// Synchroniser and debounce
	// ****************************************
	localparam int CW = $clog2(DEB_CNT + 1);
	localparam int MW = $clog2(MOM_CNT + 1);
	logic [NUM_CH-1:0] s1_q, s2_q;
	logic [NUM_CH-1:0] stab_q, stab_d;
	logic [CW-1:0] cnt_q [NUM_CH];
	logic [CW-1:0] cnt_d [NUM_CH];
	logic [NUM_CH-1:0] fall, rise;

	// Reset assumes open contacts, so no false edge follows reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s1_q <= '1;
			s2_q <= '1;
		end else begin
			s1_q <= contact_n;
			s2_q <= s1_q;
		end
	end

	always_comb begin
		stab_d = stab_q;
		fall = '0;
		rise = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			cnt_d[i] = '0;
			// Level must hold for the full window, so bounce never leaks
			if (s2_q[i] != stab_q[i]) begin
				if (cnt_q[i] == CW'(DEB_CNT - 1)) begin
					stab_d[i] = s2_q[i];
					fall[i] = ~s2_q[i];
					rise[i] = s2_q[i];
				end else begin
					cnt_d[i] = cnt_q[i] + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			stab_q <= '1;
			for (int i = 0; i < NUM_CH; i++) cnt_q[i] <= '0;
		end else begin
			stab_q <= stab_d;
			for (int i = 0; i < NUM_CH; i++) cnt_q[i] <= cnt_d[i];
		end
	end

	// ****************************************
	// Normal functions
	// ****************************************
	prcc_ctrl_t ctrl_q, ctrl_d;
	logic [MW-1:0] mom_q, mom_d;
	logic jam_q, jam_d;

	always_comb begin
		ctrl_d = ctrl_q;
		mom_d = mom_q;
		jam_d = 1'b0;
		if (!remote_mode) begin
			if (fall[CH_KEYER]) ctrl_d.keyer_on = 1'b1;
			if (rise[CH_KEYER]) ctrl_d.keyer_on = 1'b0;
			if (fall[CH_JAM]) ctrl_d.jam_cont = 1'b1;
			if (rise[CH_JAM]) ctrl_d.jam_cont = 1'b0;
			if (fall[CH_GEN_EN]) ctrl_d.vitc_gen_on = 1'b1;
			if (rise[CH_GEN_EN]) ctrl_d.vitc_gen_on = 1'b0;
			if (rise[CH_TIME_UB] && ctrl_q.ub_mode == PRCC_UB_RTIME)
				ctrl_d.ub_mode = PRCC_UB_STATIC;
			if (rise[CH_UB_UB] && ctrl_q.ub_mode == PRCC_UB_RUB)
				ctrl_d.ub_mode = PRCC_UB_STATIC;
			// Falls come last, so a closure beats a release in one cycle
			if (fall[CH_TIME_UB]) ctrl_d.ub_mode = PRCC_UB_RTIME;
			if (fall[CH_UB_UB]) ctrl_d.ub_mode = PRCC_UB_RUB;
			// Low time of the jam input, saturating
			if (fall[CH_JAM]) mom_d = '0;
			else if (!stab_q[CH_JAM] && mom_q != MW'(MOM_CNT))
				mom_d = mom_q + 1'b1;
			if (rise[CH_JAM] && mom_q < MW'(MOM_CNT))
				jam_d = 1'b1;
		end else begin
			// Saturate, so a release after remote mode is no one-shot
			mom_d = MW'(MOM_CNT);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_q <= '{1'b0, 1'b0, 1'b0, PRCC_UB_STATIC};
			mom_q <= '0;
			jam_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			mom_q <= mom_d;
			jam_q <= jam_d;
		end
	end

	assign ctrl = ctrl_q;
	assign jam_once = jam_q;

	// ****************************************
	// Remote user bits
	// ****************************************
	function automatic logic [7:0] enc_ub(input logic [NUM_CH-1:0] lv);
		logic [7:0] r;
		r = UB_IDLE;
		// Lowest index wins when several inputs are closed
		if (!lv[CH_KEYER]) r = UB_CODE_KEYER;
		if (!lv[CH_JAM]) r = UB_CODE_JAM;
		if (!lv[CH_GEN_EN]) r = UB_CODE_GEN_EN;
		if (!lv[CH_UB_UB]) r = UB_CODE_UB_UB;
		if (!lv[CH_TIME_UB]) r = UB_CODE_TIME_UB;
		return r;
	endfunction

	logic src_q, src_d;
	logic [7:0] ub_q, ub_d;
	logic ser_hit;

	always_comb begin
		ser_hit = serial_cmd_valid && serial_cmd == CMD_SET_REMOTE_UB;
		src_d = src_q;
		ub_d = ub_q;
		// An edge outranks a serial load in the same cycle
		if (|(fall | rise)) src_d = 1'b1;
		else if (ser_hit) src_d = 1'b0;
		if (remote_mode) begin
			if (src_d) ub_d = enc_ub(stab_d);
			else if (ser_hit) ub_d = serial_ub;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			src_q <= 1'b1;
			ub_q <= UB_IDLE;
		end else begin
			src_q <= src_d;
			ub_q <= ub_d;
		end
	end

	assign generator_user_bits = ub_q;
	assign src_parallel = src_q;

	// ****************************************
	// Checks
	// ****************************************
	a_keyer_fall_on: assert property (@(posedge core_clk) disable iff (rst)
		!remote_mode && fall[CH_KEYER] |=> ctrl_q.keyer_on)
		else $error("keyer not on after fall");
	a_keyer_rise_off: assert property (@(posedge core_clk) disable iff (rst)
		!remote_mode && rise[CH_KEYER] |=> !ctrl_q.keyer_on)
		else $error("keyer not off after rise");
	a_jam_cont_on: assert property (@(posedge core_clk) disable iff (rst)
		!remote_mode && fall[CH_JAM] |=> ctrl_q.jam_cont)
		else $error("jam not on");
	a_jam_once_pulse: assert property (@(posedge core_clk) disable iff (rst)
		jam_q |-> $past(rise[CH_JAM]) && !$past(remote_mode))
		else $error("jam pulse without release");
	a_gen_enable: assert property (@(posedge core_clk) disable iff (rst)
		!remote_mode && fall[CH_GEN_EN] |=> ctrl_q.vitc_gen_on)
		else $error("generator not on");
	a_time_ub_mode: assert property (@(posedge core_clk) disable iff (rst)
		!remote_mode && fall[CH_TIME_UB] && !fall[CH_UB_UB]
		|=> ctrl_q.ub_mode == PRCC_UB_RTIME)
		else $error("time ub mode missing");
	a_ub_ub_mode: assert property (@(posedge core_clk) disable iff (rst)
		!remote_mode && fall[CH_UB_UB] |=> ctrl_q.ub_mode == PRCC_UB_RUB)
		else $error("ub ub mode missing");
	a_remote_freeze: assert property (@(posedge core_clk) disable iff (rst)
		remote_mode |=> $stable(ctrl_q))
		else $error("functions changed in remote mode");
	a_edge_src: assert property (@(posedge core_clk) disable iff (rst)
		|(fall | rise) |=> src_q)
		else $error("edge did not reselect parallel");
	a_serial_load: assert property (@(posedge core_clk) disable iff (rst)
		remote_mode && ser_hit && !(|(fall | rise))
		|=> !src_q && ub_q == $past(serial_ub))
		else $error("serial load failed");
	a_keyer_code: assert property (@(posedge core_clk) disable iff (rst)
		remote_mode && src_d && stab_d == 5'h0f |=> ub_q == UB_CODE_KEYER)
		else $error("keyer code wrong");
	a_debounce_hold: assert property (@(posedge core_clk) disable iff (rst)
		s2_q[CH_KEYER] == stab_q[CH_KEYER] |=> !fall[CH_KEYER] && !rise[CH_KEYER])
		else $error("edge without level change");

	// ****************************************
	// Checks, normal functions and debounce edges
	// ****************************************
	a_keyer_hold: assert property (@(posedge core_clk) disable iff (rst)
		!fall[CH_KEYER] && !rise[CH_KEYER] |=> $stable(ctrl_q.keyer_on))
		else $error("keyer changed without edge");
	a_jam_cont_off: assert property (@(posedge core_clk) disable iff (rst)
		!remote_mode && rise[CH_JAM] |=> !ctrl_q.jam_cont)
		else $error("jam not off");
	a_jam_cont_hold: assert property (@(posedge core_clk) disable iff (rst)
		!fall[CH_JAM] && !rise[CH_JAM] |=> $stable(ctrl_q.jam_cont))
		else $error("jam changed without edge");
	a_jam_once_single: assert property (@(posedge core_clk) disable iff (rst)
		jam_q |=> !jam_q)
		else $error("jam pulse too long");
	a_jam_short_fires: assert property (@(posedge core_clk) disable iff (rst)
		!remote_mode && rise[CH_JAM] && mom_q < MW'(MOM_CNT) |=> jam_q)
		else $error("short jam press gave no pulse");
	a_jam_long_quiet: assert property (@(posedge core_clk) disable iff (rst)
		rise[CH_JAM] && mom_q == MW'(MOM_CNT) |=> !jam_q)
		else $error("long jam press gave a pulse");
	a_jam_low_start: assert property (@(posedge core_clk) disable iff (rst)
		!remote_mode && fall[CH_JAM] |=> mom_q == '0)
		else $error("low time not restarted");
	a_gen_disable: assert property (@(posedge core_clk) disable iff (rst)
		!remote_mode && rise[CH_GEN_EN] |=> !ctrl_q.vitc_gen_on)
		else $error("generator not off");
	a_gen_hold: assert property (@(posedge core_clk) disable iff (rst)
		!fall[CH_GEN_EN] && !rise[CH_GEN_EN] |=> $stable(ctrl_q.vitc_gen_on))
		else $error("generator changed without edge");
	a_time_ub_exit: assert property (@(posedge core_clk) disable iff (rst)
		!remote_mode && rise[CH_TIME_UB] && !fall[CH_UB_UB]
		&& ctrl_q.ub_mode == PRCC_UB_RTIME |=> ctrl_q.ub_mode == PRCC_UB_STATIC)
		else $error("time ub mode not left");
	a_ub_ub_exit: assert property (@(posedge core_clk) disable iff (rst)
		!remote_mode && rise[CH_UB_UB] && !fall[CH_TIME_UB]
		&& ctrl_q.ub_mode == PRCC_UB_RUB |=> ctrl_q.ub_mode == PRCC_UB_STATIC)
		else $error("ub ub mode not left");
	a_edge_exclusive: assert property (@(posedge core_clk) disable iff (rst)
		(fall & rise) == '0)
		else $error("fall and rise together");
	a_fall_level: assert property (@(posedge core_clk) disable iff (rst)
		fall[CH_KEYER] |=> !stab_q[CH_KEYER])
		else $error("fall left level high");
	a_rise_level: assert property (@(posedge core_clk) disable iff (rst)
		rise[CH_KEYER] |=> stab_q[CH_KEYER])
		else $error("rise left level low");

	// ****************************************
	// Checks, remote user bits
	// ****************************************
	a_remote_no_jam: assert property (@(posedge core_clk) disable iff (rst)
		remote_mode |=> !jam_q)
		else $error("jam pulse in remote mode");
	a_normal_ub_hold: assert property (@(posedge core_clk) disable iff (rst)
		!remote_mode |=> $stable(ub_q))
		else $error("user bits changed outside remote mode");
	a_parallel_follow: assert property (@(posedge core_clk) disable iff (rst)
		remote_mode && src_d |=> ub_q == enc_ub($past(stab_d)))
		else $error("user bits do not follow contacts");
	a_idle_code: assert property (@(posedge core_clk) disable iff (rst)
		remote_mode && src_d && stab_d == '1 |=> ub_q == UB_IDLE)
		else $error("idle code wrong");
	a_serial_hold: assert property (@(posedge core_clk) disable iff (rst)
		remote_mode && !src_q && !ser_hit && !(|(fall | rise))
		|=> $stable(ub_q))
		else $error("serial bits not held");
	a_serial_other: assert property (@(posedge core_clk) disable iff (rst)
		serial_cmd_valid && serial_cmd != CMD_SET_REMOTE_UB
		&& !(|(fall | rise)) |=> $stable(src_q))
		else $error("other command moved source");

	c_keyer_toggle: cover property (@(posedge core_clk) fall[CH_KEYER]);
	c_jam_once: cover property (@(posedge core_clk) jam_q);
	c_jam_cont: cover property (@(posedge core_clk)
		ctrl_q.jam_cont);
	c_serial_ub: cover property (@(posedge core_clk) remote_mode && ser_hit);
	c_remote_code: cover property (@(posedge core_clk)
		remote_mode && ub_q == UB_CODE_TIME_UB);

endmodule // prcc_contact_ctrl

// ---- common/prcc_pkg.sv ----
package prcc_pkg;
	// Input index order inside the contact vector
	localparam int CH_TIME_UB = 0;
	localparam int CH_UB_UB = 1;
	localparam int CH_GEN_EN = 2;
	localparam int CH_JAM = 3;
	localparam int CH_KEYER = 4;
	localparam int NUM_CH = 5;
	// User-bit byte 1 code per input, same index order
	localparam logic [7:0] UB_CODE_TIME_UB = 8'h81;
	localparam logic [7:0] UB_CODE_UB_UB = 8'h82;
	localparam logic [7:0] UB_CODE_GEN_EN = 8'h84;
	localparam logic [7:0] UB_CODE_JAM = 8'h88;
	localparam logic [7:0] UB_CODE_KEYER = 8'h90;
	localparam logic [7:0] UB_IDLE = 8'h00;
	// Serial command code that loads remote user bits
	localparam logic [7:0] CMD_SET_REMOTE_UB = 8'h8a;
	// Debounce settle time and cycles at 10 MHz
	localparam int DEB_TIME_US = 10000;
	localparam int CLK_MHZ = 10;
	localparam int DEB_CYCLES = DEB_TIME_US * CLK_MHZ;
	// Momentary jam: low shorter than this is a one-shot jam
	localparam int MOM_TIME_US = 500000;
	localparam int MOM_CYCLES = MOM_TIME_US * CLK_MHZ;

	typedef enum logic [1:0] {
		PRCC_UB_STATIC,
		PRCC_UB_RTIME,
		PRCC_UB_RUB
	} prcc_ub_mode_t;

	typedef struct packed {
		logic keyer_on;
		logic jam_cont;
		logic vitc_gen_on;
		prcc_ub_mode_t ub_mode;
	} prcc_ctrl_t;
endpackage

// ---- test/prcc_contact_sw.sv ----
`timescale 1ns/1ns
// ****************
// Contact closures to ground
// ****************
module prcc_contact_sw (
	input wire logic core_clk,
	input wire logic [4:0] closed,
	output logic [4:0] contact_n
);
	logic [4:0] last_q = 5'h00;
	logic [4:0] chg = 5'h00;
	int bnc = 0;
	initial contact_n = 5'h1f;
	// Real contacts chatter, so each change toggles a few cycles first
	always @(posedge core_clk) begin
		if (closed != last_q) begin
			bnc = 3;
			chg = closed ^ last_q;
		end
		last_q = closed;
		if (bnc > 0) begin
			bnc--;
			contact_n <= (bnc == 0) ? ~closed : contact_n ^ chg;
		end
	end
endmodule // prcc_contact_sw

// ---- test/parallel_remote_contact_control_bench.sv ----
`timescale 1ns/1ns
module parallel_remote_contact_control_bench;
	import prcc_pkg::*;
	logic core_clk, rst = 1, remote_mode = 0, serial_cmd_valid = 0;
	logic [4:0] closed = 0, contact_n;
	logic [7:0] serial_cmd = 0, serial_ub = 0, generator_user_bits, b;
	logic [7:0] codes [5] = '{8'h81, 8'h82, 8'h84, 8'h88, 8'h90};
	prcc_ctrl_t ctrl;
	logic jam_once, src_parallel;
	int failures = 0, check_count = 0, once_cnt = 0, k, m, e;
	prcc_contact_sw prcc_contact_sw_i (.core_clk(core_clk), .closed(closed),
		.contact_n(contact_n));
	prcc_contact_ctrl #(.DEB_CNT(4), .MOM_CNT(50)) prcc_contact_ctrl_i (
		.core_clk(core_clk), .rst(rst), .contact_n(contact_n),
		.remote_mode(remote_mode), .serial_cmd_valid(serial_cmd_valid),
		.serial_cmd(serial_cmd), .serial_ub(serial_ub), .ctrl(ctrl),
		.jam_once(jam_once), .generator_user_bits(generator_user_bits),
		.src_parallel(src_parallel));
	initial begin
		core_clk = 0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) if (jam_once === 1'b1) once_cnt++;
	task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s exp %h got %h", name, exp, got);
		end
	endtask
	task automatic pins(logic [4:0] v, int n);
		@(posedge core_clk);
		closed <= v;
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic ser(logic [7:0] c, logic [7:0] u);
		@(posedge core_clk);
		serial_cmd_valid <= 1;
		serial_cmd <= c;
		serial_ub <= u;
		@(posedge core_clk);
		serial_cmd_valid <= 0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	task automatic wrap_up;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#1_000_000;
		failures++;
		wrap_up();
	end
	initial begin
		k = $urandom(32'h8e0bca57);
		repeat (6) @(posedge core_clk);
		rst <= 0;
		pins(0, 2);
		chk("ub", 8'h00, generator_user_bits);
		chk("src", 8'h01, 8'(src_parallel));
		// ****************
		// Edge functions, long jam hold
		// ****************
		for (k = 0; k < 5; k++) begin
			pins(5'h01 << k, 80);
			chk("ctrl", (k < 2) ? 8'(k + 1) : 8'(5'h01 << k), 8'(ctrl));
			pins(0, 20);
			chk("ctrl", 8'h00, 8'(ctrl));
		end
		chk("once", 8'h00, 8'(once_cnt));
		pins(5'h08, 20);
		pins(0, 20);
		chk("once", 8'h01, 8'(once_cnt));
		$display("test edges done");
		// ****************
		// Remote contact user bits
		// ****************
		remote_mode <= 1;
		for (m = 0; m < 8; m++) begin
			b = 8'($urandom & 5'h1f);
			pins(b[4:0], 20);
			e = 5;
			for (k = 4; k >= 0; k--) if (b[k]) e = k;
			chk("ub", (e < 5) ? codes[e] : 8'h00, generator_user_bits);
			chk("ctrl", 8'h00, 8'(ctrl));
		end
		chk("once", 8'h01, 8'(once_cnt));
		pins(0, 20);
		b = 8'($urandom);
		ser(CMD_SET_REMOTE_UB, b);
		chk("ub", b, generator_user_bits);
		chk("src", 8'h00, 8'(src_parallel));
		ser(8'h8b, ~b);
		chk("ub", b, generator_user_bits);
		pins(5'h02, 20);
		chk("src", 8'h01, 8'(src_parallel));
		chk("ub", 8'h82, generator_user_bits);
		pins(0, 20);
		$display("test remote done");
		remote_mode <= 0;
		pins(5'h10, 20);
		chk("ctrl", 8'h10, 8'(ctrl));
		pins(0, 20);
		$display("test restore done");
		wrap_up();
	end
endmodule // parallel_remote_contact_control_bench
